/* pmbus_window_cfg.svh */
`ifndef PMBUS_WINDOW_CFG_SVH
`define PMBUS_WINDOW_CFG_SVH
// Notes on behaviour
// - The revision block read holds hardware revision in 31:24, zero in 23:8, firmware in 7:0.
// - The fixed window moves four bytes to or from the pointed location; the pointer stays.
// - Both windows map the same way; accesses with memory_space_select 000 go to the internal memory, others read zero and write nothing.
// - Each increment-window access uses the pointed location and then advances the pointer.
// - Increment-window transfers may be single words or bursts of any length.
// - Pointer bits 15:13 select the memory_space_select, 000 being RAM, and bits 12:0 the location.
// - The location field is 13 bits wide and reaches every word of the memory_space_select.
// - The peak overcurrent limit is a signed 16-bit value, 0.1 A per step, reset 01f4.
// - The peak undercurrent limit is a signed 16-bit value, 0.1 A per step, reset fe0c.
// - The output may be enabled only while the monitor pin is above the 16-bit rise threshold.
// - The rise threshold accepts any 16-bit unsigned code, 10 mV per step.
// - Current limits are taken only with page 00 selected and apply to the one rail.

`define CMD_PAGE 8'h00
`define CMD_DEVICE_REVISION 8'hae
`define CMD_MEM_WINDOW_FIXED 8'hc5
`define CMD_MEM_WINDOW_INCREMENT 8'hc6
`define CMD_MEM_INDIRECT_POINTER 8'hc7
`define CMD_PEAK_OVERCURRENT 8'hcd
`define CMD_PEAK_UNDERCURRENT 8'hce
`define CMD_MONITOR_RISE 8'hd0

`define RST_PAGE 8'h00
`define RST_POINTER 16'h0000
`define RST_PEAK_OVERCURRENT 16'h01f4
`define RST_PEAK_UNDERCURRENT 16'hfe0c
`define RST_MONITOR_RISE 16'h01c2

`define HW_REV_MSB 31
`define HW_REV_LSB 24
`define FW_REV_MSB 7
`define FW_REV_LSB 0
`define MEMORY_SPACE_SELECT_MSB 15
`define MEMORY_SPACE_SELECT_LSB 13
`define LOCATION_MSB 12
`define LOCATION_LSB 0
`define LOCATION_W 13
`define MEMORY_SPACE_SELECT_RAM 3'h0

`define PAGE_RAIL 8'h00
`define BLOCK_COUNT 8'h04
`define LEN_WORD 3'h4
`define LEN_HALF 3'h2
`define LEN_BYTE 3'h1
`define LEN_NONE 3'h0
`define LAST_WORD_BYTE 3'h3
`define MAX_READ_INDEX 3'h7
`endif

/* pmbus_window_pkg.sv */
`include "pmbus_window_cfg.svh"
package pmbus_window_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] half_t;
   typedef logic [31:0] word_t;
   typedef enum logic [3:0] {
      K_NONE, K_PAGE, K_REV, K_FIXED, K_INCR, K_PTR, K_OC, K_UC, K_MON
   } cmd_kind_e;

   function automatic cmd_kind_e decode_cmd(input byte_t c);
      case (c)
         `CMD_PAGE: decode_cmd = K_PAGE;
         `CMD_DEVICE_REVISION: decode_cmd = K_REV;
         `CMD_MEM_WINDOW_FIXED: decode_cmd = K_FIXED;
         `CMD_MEM_WINDOW_INCREMENT: decode_cmd = K_INCR;
         `CMD_MEM_INDIRECT_POINTER: decode_cmd = K_PTR;
         `CMD_PEAK_OVERCURRENT: decode_cmd = K_OC;
         `CMD_PEAK_UNDERCURRENT: decode_cmd = K_UC;
         `CMD_MONITOR_RISE: decode_cmd = K_MON;
         default: decode_cmd = K_NONE;
      endcase
   endfunction

   // bytes a write carries; revision is read only so takes none
   function automatic logic [2:0] write_len(input cmd_kind_e k);
      case (k)
         K_PAGE: write_len = `LEN_BYTE;
         K_FIXED, K_INCR: write_len = `LEN_WORD;
         K_PTR, K_OC, K_UC, K_MON: write_len = `LEN_HALF;
         default: write_len = `LEN_NONE;
      endcase
   endfunction
endpackage

/* two_entry_buffer.sv */
`timescale 1ns/1ns
module two_entry_buffer #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input wire logic clk_in,                // core clock
   input wire logic arst_n_in,             // async reset, active low
   input wire logic in_valid_in,           // word offered
   output logic in_ready_out,              // room for a word
   input wire logic [WIDTH-1:0] in_data_in, // word in
   output logic out_valid_out,             // word available
   input wire logic out_ready_in,          // drain takes word
   output logic [WIDTH-1:0] out_data_out   // oldest word
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] slot [0:DEPTH-1];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   wire push = in_valid_in & in_ready_out;
   wire pop = out_valid_out & out_ready_in;

   assign in_ready_out = (count != DEPTH[PW:0]);
   assign out_valid_out = (count != '0);
   assign out_data_out = slot[rd_ptr];

   always_ff @(posedge clk_in) begin
      if (push) begin
         slot[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

/* pmbus_memory_window_limits.sv */
`timescale 1ns/1ns
`include "pmbus_window_cfg.svh"
module pmbus_memory_window_limits
   import pmbus_window_pkg::*;
#(
   parameter logic [7:0] HW_REVISION = 8'h01, // arbitrary value
   parameter logic [7:0] FW_REVISION = 8'h01  // arbitrary value
) (
   input wire logic core_clk_in,                  // core clock, 125 MHz
   input wire logic arst_n_in,                    // async reset, active low
   input wire logic link_clk_in,                  // command link clock
   input wire logic link_wr_valid_in,             // host offers a byte
   input wire logic link_wr_first_in,             // byte is a command code
   input wire logic [7:0] link_wr_byte_in,        // byte from host
   output logic link_wr_ready_out,                // byte will be taken
   input wire logic link_rd_req_in,               // host asks next read byte
   output logic link_rd_valid_out,                // read byte pulse
   output logic [7:0] link_rd_byte_out,           // read byte
   input wire logic [15:0] input_monitor_pin_in,  // monitor pin code, core clock
   output logic output_enable_permit_out,         // monitor above rise level
   output logic [15:0] phase_peak_overcurrent_limit_out,  // signed, 0.1 A step
   output logic [15:0] phase_peak_undercurrent_limit_out, // signed, 0.1 A step
   output logic [15:0] monitor_rise_threshold_out         // unsigned, 10 mV step
);
   localparam int RAM_WORDS = 1 << `LOCATION_W;

   ////////////////////////////////////////////////////////////////////////////////
   // link domain: write bytes cross by toggle handshake
   // reset release is not synchronised here; hold it across several edges of both clocks

   logic l_req_tgl;
   logic l_ack_s1;
   logic l_ack_s2;
   logic [8:0] l_wr_word;
   logic l_rreq_tgl;
   logic l_rack_s1;
   logic l_rack_s2;
   logic l_rack_seen;
   // core-side handshake state, declared here because the link logic samples it
   logic c_ack_tgl;
   logic c_rack_tgl;
   logic [7:0] c_rd_byte;

   wire l_accept = link_wr_valid_in & link_wr_ready_out;
   wire l_pending = l_req_tgl ^ l_ack_s2;
   wire next_wr_ready = ~(l_accept | l_pending);
   wire l_rd_busy = l_rreq_tgl ^ l_rack_seen;
   wire l_rd_take = link_rd_req_in & ~l_rd_busy;
   wire l_rd_done = l_rack_s2 ^ l_rack_seen;

   // word stays put until the ack returns, so the core may read it directly
   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         l_req_tgl <= 1'b0;
         l_wr_word <= '0;
         link_wr_ready_out <= 1'b1;
      end else begin
         link_wr_ready_out <= next_wr_ready;
         if (l_accept) begin
            l_req_tgl <= ~l_req_tgl;
            l_wr_word <= {link_wr_first_in, link_wr_byte_in};
         end
      end
   end

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         l_ack_s1 <= 1'b0;
         l_ack_s2 <= 1'b0;
         l_rack_s1 <= 1'b0;
         l_rack_s2 <= 1'b0;
      end else begin
         l_ack_s1 <= c_ack_tgl;
         l_ack_s2 <= l_ack_s1;
         l_rack_s1 <= c_rack_tgl;
         l_rack_s2 <= l_rack_s1;
      end
   end

   // a read request while one is outstanding is dropped
   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         l_rreq_tgl <= 1'b0;
         l_rack_seen <= 1'b0;
         link_rd_valid_out <= 1'b0;
         link_rd_byte_out <= '0;
      end else begin
         if (l_rd_take) l_rreq_tgl <= ~l_rreq_tgl;
         link_rd_valid_out <= l_rd_done;
         if (l_rd_done) begin
            l_rack_seen <= l_rack_s2;
            link_rd_byte_out <= c_rd_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // core domain: crossing and buffering

   logic c_req_s1;
   logic c_req_s2;
   logic c_rreq_s1;
   logic c_rreq_s2;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [8:0] buf_out_data;
   logic mem_busy;

   wire c_new_word = c_req_s2 ^ c_ack_tgl;
   wire buf_push = c_new_word & buf_in_ready;
   // the drain stalls for the memory write cycle, letting the buffer fill
   wire buf_out_ready = ~mem_busy;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         c_req_s1 <= 1'b0;
         c_req_s2 <= 1'b0;
         c_rreq_s1 <= 1'b0;
         c_rreq_s2 <= 1'b0;
         c_ack_tgl <= 1'b0;
      end else begin
         c_req_s1 <= l_req_tgl;
         c_req_s2 <= c_req_s1;
         c_rreq_s1 <= l_rreq_tgl;
         c_rreq_s2 <= c_rreq_s1;
         if (buf_push) c_ack_tgl <= c_req_s2;
      end
   end

   // nine bits wide: the command flag travels with its byte
   two_entry_buffer #(
      .WIDTH(9),
      .DEPTH(2)
   ) u_byte_buffer (
      .clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .in_valid_in(c_new_word),
      .in_ready_out(buf_in_ready),
      .in_data_in(l_wr_word),
      .out_valid_out(buf_out_valid),
      .out_ready_in(buf_out_ready),
      .out_data_out(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // command engine

   logic [7:0] cmd;
   logic [7:0] page;
   logic [2:0] wr_idx;
   logic [2:0] rd_idx;
   word_t acc;
   word_t merged;
   word_t rd_word;
   half_t pointer;
   half_t oc_limit;
   half_t uc_limit;
   half_t rise_level;
   logic [`LOCATION_W-1:0] mem_addr;
   word_t mem_data;
   logic mem_ok;
   word_t mem [0:RAM_WORDS-1];

   wire take = buf_out_valid & buf_out_ready;
   wire in_first = buf_out_data[8];
   wire [7:0] in_byte = buf_out_data[7:0];
   wire cmd_kind_e kind = decode_cmd(cmd);
   wire [2:0] len = write_len(kind);
   wire is_window = (kind == K_FIXED) || (kind == K_INCR);
   wire wr_last = take & ~in_first & (len != `LEN_NONE) & (wr_idx == len - 3'h1);
   wire rail_page = (page == `PAGE_RAIL);

   wire [2:0] ptr_memory_space_select = pointer[`MEMORY_SPACE_SELECT_MSB:`MEMORY_SPACE_SELECT_LSB];
   wire [`LOCATION_W-1:0] ptr_loc = pointer[`LOCATION_MSB:`LOCATION_LSB];
   wire memory_space_select_ram = (ptr_memory_space_select == `MEMORY_SPACE_SELECT_RAM);
   wire half_t ptr_advanced = {ptr_memory_space_select, ptr_loc + 13'h0001};
   wire half_t merged_ptr = merged[15:0];
   wire word_t fetch_word = memory_space_select_ram ? mem[ptr_loc] : 32'h0000_0000;

   // reads wait for queued writes so they see the latest state
   wire rd_new = (c_rreq_s2 ^ c_rack_tgl) & ~buf_out_valid & ~mem_busy;
   wire win_fetch = is_window & (rd_idx == 3'h0);
   wire win_last = is_window & (rd_idx == `LAST_WORD_BYTE);

   always_comb begin
      merged = acc;
      merged[{wr_idx[1:0], 3'b000} +: 8] = in_byte;
   end

   wire word_t rev_word = {HW_REVISION, 16'h0000, FW_REVISION};
   wire word_t reg_word =
      (kind == K_PAGE) ? {24'h00_0000, page} :
      (kind == K_PTR) ? {16'h0000, pointer} :
      (kind == K_OC) ? {16'h0000, oc_limit} :
      (kind == K_UC) ? {16'h0000, uc_limit} :
      (kind == K_MON) ? {16'h0000, rise_level} :
      is_window ? (win_fetch ? fetch_word : rd_word) : 32'h0000_0000;
   // block read leads with its byte count
   wire [63:0] rd_vector = (kind == K_REV) ? {24'h00_0000, rev_word, `BLOCK_COUNT} :
      {32'h0000_0000, reg_word};
   wire [7:0] rd_sel = rd_vector[{rd_idx, 3'b000} +: 8];
   wire [2:0] next_rd_idx = win_last ? 3'h0 :
      (rd_idx == `MAX_READ_INDEX) ? rd_idx : rd_idx + 3'h1;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmd <= 8'h00;
         wr_idx <= 3'h0;
         acc <= 32'h0000_0000;
      end else if (take) begin
         if (in_first) begin
            cmd <= in_byte;
            wr_idx <= 3'h0;
         end else begin
            acc <= merged;
            wr_idx <= wr_last ? 3'h0 : wr_idx + 3'h1;
         end
      end
   end

   // settings registers
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         page <= `RST_PAGE;
         oc_limit <= `RST_PEAK_OVERCURRENT;
         uc_limit <= `RST_PEAK_UNDERCURRENT;
         rise_level <= `RST_MONITOR_RISE;
      end else if (wr_last) begin
         if (kind == K_PAGE) page <= merged[7:0];
         if (kind == K_OC && rail_page) oc_limit <= merged[15:0];
         if (kind == K_UC && rail_page) uc_limit <= merged[15:0];
         if (kind == K_MON) rise_level <= merged[15:0];
      end
   end

   // pointer: written by the host, advanced by the increment window
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pointer <= `RST_POINTER;
      end else if (wr_last && kind == K_PTR) begin
         pointer <= merged_ptr;
      end else if (wr_last && kind == K_INCR) begin
         pointer <= ptr_advanced;
      end else if (rd_new && win_last && kind == K_INCR) begin
         pointer <= ptr_advanced;
      end
   end

   // window writes land one cycle later; fixed window leaves the pointer
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mem_busy <= 1'b0;
         mem_ok <= 1'b0;
         mem_addr <= '0;
         mem_data <= 32'h0000_0000;
      end else begin
         mem_busy <= wr_last & is_window;
         if (wr_last && is_window) begin
            mem_ok <= memory_space_select_ram;
            mem_addr <= ptr_loc;
            mem_data <= merged;
         end
      end
   end

   // memory contents are not reset; only memory_space_select 000 is backed
   always_ff @(posedge core_clk_in) begin
      if (mem_busy && mem_ok) begin
         mem[mem_addr] <= mem_data;
      end
   end

   // read service; the window word is latched on its first byte
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_idx <= 3'h0;
         rd_word <= 32'h0000_0000;
         c_rd_byte <= 8'h00;
         c_rack_tgl <= 1'b0;
      end else if (take && in_first) begin
         rd_idx <= 3'h0;
      end else if (rd_new) begin
         c_rack_tgl <= c_rreq_s2;
         c_rd_byte <= rd_sel;
         rd_idx <= next_rd_idx;
         if (win_fetch) rd_word <= fetch_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // limits and monitor gating
   // strictly above: a pin level equal to the threshold does not yet permit

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         output_enable_permit_out <= 1'b0;
      end else begin
         output_enable_permit_out <= (input_monitor_pin_in > rise_level);
      end
   end

   assign phase_peak_overcurrent_limit_out = oc_limit;
   assign phase_peak_undercurrent_limit_out = uc_limit;
   assign monitor_rise_threshold_out = rise_level;
endmodule

/* pmbus_window_props.sv */
`timescale 1ns/1ns
module pmbus_window_props
   import pmbus_window_pkg::*;
(
   input wire logic core_clk_in, // core clock
   input wire logic arst_n_in, // async reset
   input wire logic link_clk_in, // link clock
   input wire logic link_wr_valid_in, // host byte offered
   input wire logic link_wr_ready_out, // byte taken
   input wire logic link_rd_req_in, // read request
   input wire logic link_rd_valid_out, // read pulse
   input wire logic [15:0] input_monitor_pin_in, // monitor code
   input wire logic output_enable_permit_out, // permit
   input wire logic [15:0] phase_peak_overcurrent_limit_out, // oc limit
   input wire logic [15:0] phase_peak_undercurrent_limit_out, // uc limit
   input wire logic [15:0] monitor_rise_threshold_out // rise threshold
);
   a_permit_strict_compare: assert property (@(posedge core_clk_in)
      disable iff (!arst_n_in) $past(arst_n_in) |-> output_enable_permit_out ==
      $past(input_monitor_pin_in > monitor_rise_threshold_out))
      else $error("permit does not follow the monitor compare");
   a_oc_reset_value: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !$past(arst_n_in) |-> phase_peak_overcurrent_limit_out == 16'h01f4)
      else $error("overcurrent limit wrong after reset");
   a_uc_reset_value: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !$past(arst_n_in) |-> phase_peak_undercurrent_limit_out == 16'hfe0c)
      else $error("undercurrent limit wrong after reset");
   a_rise_reset_value: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
      !$past(arst_n_in) |-> monitor_rise_threshold_out == 16'h01c2)
      else $error("rise threshold wrong after reset");
   a_rd_one_cycle: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
      link_rd_valid_out |=> !link_rd_valid_out)
      else $error("read pulse longer than one cycle");
   a_rd_answers_req: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
      link_rd_req_in && !link_rd_valid_out |-> ##[1:20] link_rd_valid_out)
      else $error("read request not answered");
   a_ready_drops_taken: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
      link_wr_valid_in && link_wr_ready_out |=> !link_wr_ready_out)
      else $error("ready stays high after a byte is taken");
   a_link_idle_reset: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
      !$past(arst_n_in) |-> link_wr_ready_out && !link_rd_valid_out)
      else $error("link not idle after reset");
endmodule
bind pmbus_memory_window_limits pmbus_window_props chk (.core_clk_in(core_clk_in),
   .arst_n_in(arst_n_in), .link_clk_in(link_clk_in), .link_wr_valid_in(link_wr_valid_in),
   .link_wr_ready_out(link_wr_ready_out), .link_rd_req_in(link_rd_req_in),
   .link_rd_valid_out(link_rd_valid_out), .input_monitor_pin_in(input_monitor_pin_in),
   .output_enable_permit_out(output_enable_permit_out),
   .phase_peak_overcurrent_limit_out(phase_peak_overcurrent_limit_out),
   .phase_peak_undercurrent_limit_out(phase_peak_undercurrent_limit_out),
   .monitor_rise_threshold_out(monitor_rise_threshold_out));

/* pmbus_host_model.sv */
`timescale 1ns/1ns
module pmbus_host_model (
   output logic link_clk_out, // link clock, stops between transfers
   output logic wr_valid_out, // byte offered
   output logic wr_first_out, // byte is a command
   output logic [7:0] wr_byte_out, // byte
   input wire logic wr_ready_in, // byte taken
   output logic rd_req_out, // read request pulse
   input wire logic rd_valid_in, // read byte pulse
   input wire logic [7:0] rd_byte_in // read byte
);
   logic run;
   int tmo;
   initial begin
      run = 1'b1;
      tmo = 0;
      link_clk_out = 1'b0;
      wr_valid_out = 1'b0;
      wr_first_out = 1'b0;
      wr_byte_out = 8'h00;
      rd_req_out = 1'b0;
      #7;
      forever #24 link_clk_out = run ? ~link_clk_out : 1'b0;
   end
   // released lines show the inverse so a stale byte is never mistaken for a held one
   task automatic send(input logic first, input logic [7:0] b);
      int n;
      run = 1'b1;
      @(negedge link_clk_out);
      wr_valid_out = 1'b1;
      wr_first_out = first;
      wr_byte_out = b;
      n = 0;
      do begin
         @(posedge link_clk_out);
         n++;
      end while (!wr_ready_in && n < 100);
      if (!wr_ready_in) tmo++;
      @(negedge link_clk_out);
      wr_valid_out = 1'b0;
      wr_first_out = ~first;
      wr_byte_out = ~b;
   endtask
   task automatic get(output logic [7:0] b);
      int n;
      run = 1'b1;
      @(negedge link_clk_out);
      rd_req_out = 1'b1;
      @(negedge link_clk_out);
      rd_req_out = 1'b0;
      n = 0;
      do begin
         @(posedge link_clk_out);
         n++;
      end while (!rd_valid_in && n < 100);
      if (!rd_valid_in) tmo++;
      b = rd_byte_in;
   endtask
   task automatic stop();
      repeat (4) @(negedge link_clk_out);
      run = 1'b0;
   endtask
endmodule

/* pmbus_memory_window_limits_tb.sv */
`timescale 1ns/1ns
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected %s expected %h seen %h", name, exp, got); end end
module pmbus_memory_window_limits_tb
   import pmbus_window_pkg::*;
;
   typedef struct {byte_t cmd; half_t val;} row_s;
   logic core_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   half_t pin = 16'h0000;
   logic lclk, wv, wf, wr, rq, rv, permit;
   byte_t wb, rb, lo;
   half_t oc, uc, thr, h;
   word_t w;
   int errors = 0;
   int check_count = 0;
   row_s rows [6] = '{'{8'hcd, 16'h8001}, '{8'hce, 16'h7fff}, '{8'hd0, 16'hffff},
      '{8'hc7, 16'he005}, '{8'hcd, 16'h0000}, '{8'hd0, 16'h0000}};
   pmbus_memory_window_limits #(.HW_REVISION(8'h5a), .FW_REVISION(8'ha3)) dut ( // arbitrary
      .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .link_clk_in(lclk),
      .link_wr_valid_in(wv), .link_wr_first_in(wf), .link_wr_byte_in(wb),
      .link_wr_ready_out(wr), .link_rd_req_in(rq), .link_rd_valid_out(rv),
      .link_rd_byte_out(rb), .input_monitor_pin_in(pin), .output_enable_permit_out(permit),
      .phase_peak_overcurrent_limit_out(oc), .phase_peak_undercurrent_limit_out(uc),
      .monitor_rise_threshold_out(thr));
   pmbus_host_model host (.link_clk_out(lclk), .wr_valid_out(wv), .wr_first_out(wf),
      .wr_byte_out(wb), .wr_ready_in(wr), .rd_req_out(rq), .rd_valid_in(rv), .rd_byte_in(rb));
   always #4 core_clk_in = ~core_clk_in;
   task automatic wr16(input byte_t c, input half_t v);
      host.send(1'b1, c);
      host.send(1'b0, v[7:0]);
      host.send(1'b0, v[15:8]);
      host.stop();
   endtask
   task automatic rd16(input byte_t c, output half_t v);
      byte_t a, b;
      host.send(1'b1, c);
      host.get(a);
      host.get(b);
      host.stop();
      v = {b, a};
   endtask
   task automatic wrw(input word_t v);
      for (int i = 0; i < 4; i++) host.send(1'b0, v[8*i +: 8]);
   endtask
   task automatic rdw(output word_t v);
      for (int i = 0; i < 4; i++) host.get(v[8*i +: 8]);
   endtask
   task automatic do_reset();
      host.run = 1'b1;
      @(negedge core_clk_in);
      arst_n_in = 1'b0;
      repeat (20) @(negedge core_clk_in);
      arst_n_in = 1'b1;
      host.stop();
   endtask
   task automatic set_pin(input half_t v);
      @(negedge core_clk_in);
      pin = v;
      repeat (3) @(negedge core_clk_in);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr16(rows[i].cmd, rows[i].val);
         rd16(rows[i].cmd, h);
         `CHK("readback", rows[i].val, h)
      end
      `CHK("oc port", 16'h0000, oc)
      `CHK("uc port", 16'h7fff, uc)
      `CHK("rise port", 16'h0000, thr)
      set_pin(16'h0001);
      `CHK("permit", 1'b1, permit)
      set_pin(16'h0000);
      `CHK("permit", 1'b0, permit)
      do_reset();
      `CHK("oc reset", 16'h01f4, oc)
      `CHK("uc reset", 16'hfe0c, uc)
      `CHK("rise reset", 16'h01c2, thr)
      rd16(8'hc7, h);
      `CHK("pointer reset", 16'h0000, h)
      set_pin(16'h01c3);
      `CHK("permit", 1'b1, permit)
      set_pin(16'h01c2);
      `CHK("permit", 1'b0, permit)
      host.send(1'b1, 8'hae);
      host.get(lo);
      `CHK("rev count", 8'h04, lo)
      rdw(w);
      `CHK("revision", 32'h5a0000a3, w)
      host.send(1'b1, 8'h00);
      host.send(1'b0, 8'h01);
      wr16(8'hcd, 16'h1234);
      rd16(8'hcd, h);
      `CHK("paged oc", 16'h01f4, oc)
      `CHK("paged read", 16'h01f4, h)
      host.send(1'b1, 8'h00);
      host.send(1'b0, 8'h00);
      wr16(8'hc7, 16'h1ffe);
      host.send(1'b1, 8'hc6);
      for (int i = 0; i < 3; i++) wrw(32'hc0de0000 + i);
      host.stop();
      rd16(8'hc7, h);
      `CHK("pointer wrap", 16'h0001, h)
      wr16(8'hc7, 16'h1ffe);
      host.send(1'b1, 8'hc5);
      for (int i = 0; i < 2; i++) begin
         rdw(w);
         `CHK("fixed read", 32'hc0de0000, w)
      end
      host.stop();
      rd16(8'hc7, h);
      `CHK("pointer kept", 16'h1ffe, h)
      host.send(1'b1, 8'hc6);
      for (int i = 0; i < 3; i++) begin
         rdw(w);
         `CHK("burst read", 32'hc0de0000 + i, w)
      end
      host.stop();
      wr16(8'hc7, 16'h0010);
      host.send(1'b1, 8'hc5);
      wrw(32'h0bad0001);
      wrw(32'h0bad0002);
      host.stop();
      rd16(8'hc7, h);
      `CHK("pointer kept", 16'h0010, h)
      host.send(1'b1, 8'hc5);
      rdw(w);
      host.stop();
      `CHK("fixed write", 32'h0bad0002, w)
      wr16(8'hc7, 16'h2003);
      host.send(1'b1, 8'hc5);
      wrw(32'hffffffff);
      host.stop();
      host.send(1'b1, 8'hc5);
      rdw(w);
      host.stop();
      `CHK("other memory_space_select", 32'h00000000, w)
      `CHK("link waits", 0, host.tmo)
      print_verdict();
   end
endmodule
